//--- hw/srpc_pkg.sv
// constants, types and field layout of the serial register port
// assumes a 10 MHz reference clock and a host that drives the serial lines
//
// How it works
// (RQ1) reset, or chip select falling, returns the port to command mode
// (RQ2) command byte: top bit is direction, low five bits address
// (RQ3) top bit one starts a write to the addressed register
// (RQ4) serial input sampled on every falling serial clock edge of the command byte and of write data, not during a read
// (RQ5) each outgoing bit is driven at a rising serial clock edge
// (RQ6) write data starts on the falling edge after the command byte
// (RQ7) transfer ends after the register's last bit; command mode returns
// (RQ8) host keeps chip select low for the whole transfer
// (RQ9) chip select rising aborts the transfer and floats the output
// (RQ10) with chip select tied low the host finishes every transfer
// (RQ11) host spaces write data bytes at least 4 us apart
// (RQ12) a write byte cut short by chip select is discarded
// (RQ13) registers up to three bytes; first write byte is the top byte
// (RQ14) data right-justified in whole bytes; unused top bits ignored
// (RQ15) ones count cleared just before the first read bit is driven
// (RQ16) every bit shifted out in a read adds to the ones count
// (RQ17) reading the ones count recounts over its own shifted value
// (RQ18) top bit zero starts a read driven from the next rising edge
// (RQ19) read value is captured whole when the read starts
// (RQ20) output floats on the last read falling edge or chip select rise
// (RQ21) host waits 4 us after a write before a read command
// (RQ22) command bits between direction and address are ignored
package srpc_pkg;

  localparam int unsigned REF_CLK_PERIOD_NS = 100;
  localparam int unsigned WR_GAP_NS         = 4000;
  localparam int unsigned WR_GAP_CYC        =
    (WR_GAP_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int unsigned GAP_CNT_W         = $clog2(WR_GAP_CYC + 1);

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned CMD_DIR_BIT = 7;
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned MAX_BYTES  = 3;
  localparam int unsigned DATA_W     = BYTE_W * MAX_BYTES;
  localparam int unsigned LANE_W     = 2;
  localparam int unsigned BITS_W     = 5;
  localparam int unsigned BIT_IDX_W  = 3;
  localparam int unsigned CKSUM_W    = 6;
  localparam int unsigned WORD_W     = ADDR_W + LANE_W + BYTE_W;

  localparam logic [BIT_IDX_W-1:0] LAST_BIT   = 3'h7;
  localparam logic [ADDR_W-1:0]    CKSUM_ADDR = 5'h1E;
  localparam logic [LANE_W-1:0]    ONE_BYTE   = 2'h1;
  localparam logic [LANE_W-1:0]    TWO_BYTES  = 2'h2;
  localparam logic [CKSUM_W-1:0]   CKSUM_RST  = 6'h00;

  typedef enum logic [1:0] {
    SRPC_CMD   = 2'b00,
    SRPC_LOAD  = 2'b01,
    SRPC_READ  = 2'b11,
    SRPC_WRITE = 2'b10
  } srpc_state_type;

endpackage

//--- hw/srpc_fifo.sv
// small first-in first-out store with a registered output stage
// assumes one clock; both sides use valid and ready
`timescale 1ns/1ps
module srpc_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] cnt_q;
  logic             push;
  logic             pop;

  // store moves into output stage when that stage is free or drained
  assign push = i_in_valid && o_in_ready;
  assign pop  = (cnt_q != '0) && (!o_out_valid || i_out_ready);

  // storage array
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  // pointers, fill level and ready toward the source
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      cnt_q      <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q      <= cnt_q + 1'b1;
        o_in_ready <= (cnt_q + 1'b1) != FULL_CNT;
      end else if (pop && !push) begin
        cnt_q      <= cnt_q - 1'b1;
        o_in_ready <= 1'b1;
      end
    end
  end

  // registered output word
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end else if (pop) begin
      o_out_valid <= 1'b1;
      o_out_data  <= mem_q[rd_ptr_q];
    end else if (i_out_ready) begin
      o_out_valid <= 1'b0;
    end
  end
endmodule

//--- hw/srpc_serial_port.sv
// serial slave port: command byte, register read and write, ones count
// assumes serial pins are asynchronous to i_ref_clk and a register file
// that answers o_rd_addr on the same clock with data and byte width
`timescale 1ns/1ps
module srpc_serial_port
  import srpc_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic               i_sclk,
  input  wire logic               i_cs_n,
  input  wire logic               i_din,
  input  wire logic [DATA_W-1:0]  i_rd_data,
  input  wire logic [LANE_W-1:0]  i_reg_bytes,
  input  wire logic               i_wr_ready,
  output logic                    o_dout,
  output logic                    o_dout_oe,
  output logic [ADDR_W-1:0]       o_rd_addr,
  output logic                    o_wr_valid,
  output logic [ADDR_W-1:0]       o_wr_addr,
  output logic [LANE_W-1:0]       o_wr_lane,
  output logic [BYTE_W-1:0]       o_wr_data,
  output logic [CKSUM_W-1:0]      o_checksum,
  output logic                    o_gap_short
);

  srpc_state_type       state_q;
  logic                 sclk_s1_q;
  logic                 sclk_s2_q;
  logic                 sclk_s3_q;
  logic                 cs_s1_q;
  logic                 cs_s2_q;
  logic                 cs_s3_q;
  logic                 din_s1_q;
  logic                 din_s2_q;
  logic                 sclk_fall;
  logic                 sclk_rise;
  logic                 cs_low;
  logic                 cs_fall;
  logic                 cs_rise;
  logic                 port_clear;
  logic [BIT_IDX_W-1:0] bit_cnt_q;
  logic [BYTE_W-1:0]    cmd_sh_q;
  logic [BYTE_W-1:0]    cmd_next;
  logic                 cmd_done;
  logic                 dir_wr_q;
  logic [LANE_W-1:0]    bytes_left_q;
  logic [BITS_W-1:0]    bits_left_q;
  logic [DATA_W-1:0]    rd_sh_q;
  logic [LANE_W-1:0]    ld_bytes;
  logic [DATA_W-1:0]    ld_data;
  logic [BYTE_W-1:0]    wr_sh_q;
  logic [BYTE_W-1:0]    wr_next;
  logic                 byte_done;
  logic                 rd_shift;
  logic                 rd_end;
  logic                 push_valid_q;
  logic [WORD_W-1:0]    push_word_q;
  logic                 fifo_in_ready;
  logic [WORD_W-1:0]    fifo_out_word;
  logic [GAP_CNT_W-1:0] gap_cnt_q;

  // two flip-flops on every pin, a third stage for edge finding
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_s1_q <= 1'b0; // idle low: no false fall after reset
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cs_s3_q   <= 1'b1;
      din_s1_q  <= 1'b0;
      din_s2_q  <= 1'b0;
    end else begin
      sclk_s1_q <= i_sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q   <= i_cs_n;
      cs_s2_q   <= cs_s1_q;
      cs_s3_q   <= cs_s2_q;
      din_s1_q  <= i_din;
      din_s2_q  <= din_s1_q;
    end
  end

  // edge events on the synchronised pins
  assign sclk_fall  = sclk_s3_q && !sclk_s2_q;
  assign sclk_rise  = !sclk_s3_q && sclk_s2_q;
  assign cs_low     = !cs_s2_q;
  assign cs_fall    = cs_s3_q && !cs_s2_q;
  assign cs_rise    = !cs_s3_q && cs_s2_q;
  assign port_clear = !cs_low || cs_fall;

  // command byte assembly and completion
  assign cmd_next = {cmd_sh_q[BYTE_W-2:0], din_s2_q};
  assign cmd_done = (state_q == SRPC_CMD) && cs_low && !cs_fall &&
                    sclk_fall && (bit_cnt_q == LAST_BIT);

  // write byte assembly and completion
  assign wr_next   = {wr_sh_q[BYTE_W-2:0], din_s2_q};
  assign byte_done = (state_q == SRPC_WRITE) && !port_clear &&
                     sclk_fall && (bit_cnt_q == LAST_BIT);

  // read shift and read end events
  assign rd_shift = (state_q == SRPC_READ) && !port_clear && sclk_rise &&
                    (bits_left_q != '0);
  assign rd_end   = (state_q == SRPC_READ) && !port_clear && sclk_fall &&
                    (bits_left_q == '0);

  // width and right-justified value of the addressed register
  always_comb begin
    ld_bytes = (i_reg_bytes == '0) ? ONE_BYTE : i_reg_bytes;
    ld_data  = i_rd_data;
    if (o_rd_addr == CKSUM_ADDR) begin
      ld_bytes = ONE_BYTE;
      ld_data  = {{(DATA_W-CKSUM_W){1'b0}}, o_checksum}; // RQ17
    end
    // move the top used byte up to the shifter's top
    unique case (ld_bytes)
      ONE_BYTE:  ld_data = {ld_data[BYTE_W-1:0], {(2*BYTE_W){1'b0}}}; // RQ14
      TWO_BYTES: ld_data = {ld_data[2*BYTE_W-1:0], {BYTE_W{1'b0}}}; // RQ14
      default:   ld_data = ld_data;
    endcase
  end

  // transfer sequencer
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= SRPC_CMD; // RQ1
    end else if (port_clear) begin
      state_q <= SRPC_CMD; // RQ1 RQ9
    end else begin
      unique case (state_q)
        SRPC_CMD: begin
          if (cmd_done) begin
            state_q <= SRPC_LOAD;
          end
        end
        SRPC_LOAD: begin
          state_q <= dir_wr_q ? SRPC_WRITE : SRPC_READ; // RQ3 RQ18
        end
        SRPC_READ: begin
          if (rd_end) begin
            state_q <= SRPC_CMD; // RQ7
          end
        end
        SRPC_WRITE: begin
          if (byte_done && bytes_left_q == ONE_BYTE) begin
            state_q <= SRPC_CMD; // RQ7
          end
        end
      endcase
    end
  end

  // bit counter within the current byte, sampled on falling edges
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_q <= '0;
    end else if (port_clear || state_q == SRPC_LOAD) begin
      bit_cnt_q <= '0;
    end else if (sclk_fall && (state_q == SRPC_CMD ||
                               state_q == SRPC_WRITE)) begin
      bit_cnt_q <= bit_cnt_q + 1'b1; // RQ4
    end
  end

  // command shifter and decoded direction and address
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_sh_q  <= '0;
      dir_wr_q  <= 1'b0;
      o_rd_addr <= '0;
    end else begin
      if (state_q == SRPC_CMD && sclk_fall && cs_low) begin
        cmd_sh_q <= cmd_next; // RQ4
      end
      if (cmd_done) begin
        dir_wr_q  <= cmd_next[CMD_DIR_BIT]; // RQ2 RQ3 RQ18
        o_rd_addr <= cmd_next[ADDR_W-1:0]; // RQ2 RQ22
      end
    end
  end

  // byte and bit budgets of the addressed register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bytes_left_q <= '0;
      bits_left_q  <= '0;
    end else if (state_q == SRPC_LOAD) begin
      bytes_left_q <= ld_bytes; // RQ13
      bits_left_q  <= {ld_bytes, 3'h0}; // RQ14
    end else begin
      if (byte_done) begin
        bytes_left_q <= bytes_left_q - 1'b1;
      end
      if (rd_shift) begin
        bits_left_q <= bits_left_q - 1'b1;
      end
    end
  end

  // read shifter: whole value snapped at load, sent on rising edges
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_sh_q <= '0;
      o_dout  <= 1'b0;
    end else if (state_q == SRPC_LOAD && !dir_wr_q) begin
      rd_sh_q <= ld_data; // RQ19
    end else if (rd_shift) begin
      o_dout  <= rd_sh_q[DATA_W-1]; // RQ5 RQ18
      rd_sh_q <= {rd_sh_q[DATA_W-2:0], 1'b0};
    end
  end

  // output enable: on with the first read bit, off at end or abort
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dout_oe <= 1'b0;
    end else if (!cs_low || rd_end) begin
      o_dout_oe <= 1'b0; // RQ9 RQ20
    end else if (rd_shift) begin
      o_dout_oe <= 1'b1; // RQ18
    end
  end

  // ones count of the bits sent in the last read
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_checksum <= CKSUM_RST;
    end else if (state_q == SRPC_LOAD && !dir_wr_q) begin
      o_checksum <= CKSUM_RST; // RQ15
    end else if (rd_shift) begin
      o_checksum <= o_checksum +
                    {{(CKSUM_W-1){1'b0}}, rd_sh_q[DATA_W-1]}; // RQ16
    end
  end

  // write data shifter, starts right after the command byte
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_sh_q <= '0;
    end else if (state_q == SRPC_WRITE && sclk_fall && !port_clear) begin
      wr_sh_q <= wr_next; // RQ4 RQ6
    end
  end

  // finished bytes wait here for room in the store
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      push_valid_q <= 1'b0;
      push_word_q  <= '0;
    end else if (byte_done) begin
      push_valid_q <= 1'b1; // RQ12
      push_word_q  <= {o_rd_addr, bytes_left_q - 1'b1, wr_next}; // RQ13
    end else if (fifo_in_ready) begin
      push_valid_q <= 1'b0;
    end
  end

  // spacing watch between write bytes and before a read command
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      gap_cnt_q   <= '0;
      o_gap_short <= 1'b0;
    end else begin
      if (byte_done) begin
        gap_cnt_q <= GAP_CNT_W'(WR_GAP_CYC);
      end else if (gap_cnt_q != '0) begin
        gap_cnt_q <= gap_cnt_q - 1'b1;
      end
      if ((byte_done || (cmd_done && !cmd_next[CMD_DIR_BIT])) &&
          gap_cnt_q != '0) begin
        o_gap_short <= 1'b1;
      end else if (cs_fall) begin
        o_gap_short <= 1'b0;
      end
    end
  end

  // byte store toward the register file
  srpc_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_ref_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push_valid_q),
    .i_in_data   (push_word_q),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_wr_valid),
    .o_out_data  (fifo_out_word),
    .i_out_ready (i_wr_ready)
  );

  // split the stored word into address, lane and data
  assign o_wr_addr = fifo_out_word[WORD_W-1 -: ADDR_W];
  assign o_wr_lane = fifo_out_word[BYTE_W +: LANE_W];
  assign o_wr_data = fifo_out_word[BYTE_W-1:0];

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_wr_cmd;
    cmd_done && cmd_next[CMD_DIR_BIT];
  endsequence
  sequence s_load_then_write;
    (state_q == SRPC_LOAD) ##1 (state_q == SRPC_WRITE);
  endsequence
  sequence s_rd_cmd;
    cmd_done && !cmd_next[CMD_DIR_BIT];
  endsequence
  sequence s_load_then_read;
    (state_q == SRPC_LOAD) ##1 (state_q == SRPC_READ);
  endsequence

  AST_CS_FALL_CMD: assert property ( // RQ1
    cs_fall |=> state_q == SRPC_CMD && bit_cnt_q == '0)
    else $error("chip select fall did not restart command mode");

  AST_ADDR_DECODE: assert property ( // RQ2
    cmd_done |=> o_rd_addr == $past(cmd_next[ADDR_W-1:0]))
    else $error("address not taken from low command bits");

  AST_WR_START: assert property ( // RQ3
    s_wr_cmd ##1 cs_low |-> s_load_then_write)
    else $error("write command did not start a write");

  AST_RD_START: assert property ( // RQ18
    s_rd_cmd ##1 cs_low |-> s_load_then_read)
    else $error("read command did not start a read");

  AST_SAMPLE_FALL: assert property ( // RQ4
    state_q == SRPC_WRITE && !sclk_fall |=> $stable(wr_sh_q))
    else $error("write data moved without a falling edge");

  AST_DOUT_RISE: assert property ( // RQ5
    $changed(o_dout) |-> $past(sclk_rise))
    else $error("output bit changed off a rising edge");

  AST_CS_RISE_HIZ: assert property ( // RQ9
    cs_rise |=> !o_dout_oe && state_q == SRPC_CMD)
    else $error("chip select rise did not abort and float");

  AST_PARTIAL_DROP: assert property ( // RQ12
    cs_rise && !push_valid_q |=> !push_valid_q [*2])
    else $error("partial byte was pushed after abort");

  AST_CKSUM_CLEAR: assert property ( // RQ15
    state_q == SRPC_LOAD && !dir_wr_q |=> o_checksum == CKSUM_RST)
    else $error("ones count not cleared before read");

  AST_CKSUM_ADD: assert property ( // RQ16
    rd_shift |=> o_checksum ==
      $past(o_checksum) + {{(CKSUM_W-1){1'b0}}, $past(rd_sh_q[DATA_W-1])})
    else $error("ones count missed an output bit");

  AST_RD_END_HIZ: assert property ( // RQ20
    rd_end |=> !o_dout_oe && state_q == SRPC_CMD)
    else $error("output did not float at end of read");

  AST_LAST_BYTE_END: assert property ( // RQ7
    byte_done && bytes_left_q == ONE_BYTE |=> state_q == SRPC_CMD)
    else $error("write did not return to command mode");

endmodule

//--- tb/srpc_host.sv
// host-side serial master model: chip select, serial clock, data in
// assumes the bench reference clock; each serial clock phase is 4 ref clocks
`timescale 1ns/1ps
module srpc_host (
  input  wire logic i_ref_clk,
  input  wire logic i_sdo,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_din
);
  // idle levels: clock stands still, data shows no stale bit
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b1;
  end

  // wait whole ref clocks, then move just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // select the device; kept low until stop, which the abort tests call inside a byte
  task automatic start();
    o_cs_n = 1'b0;
    step(4);
  endtask

  // release select; data line no longer shows the last bit
  task automatic stop();
    o_cs_n = 1'b1;
    o_din  = ~o_din;
  endtask

  // nbits of tx msb first; answer sampled just before each fall
  task automatic shift(input logic [7:0] tx, input int nbits,
                       output logic [7:0] rx);
    rx = 8'h00;
    // bytes take 64 ref clocks, well over the byte spacing limit
    for (int i = 7; i > 7 - nbits; i--) begin
      o_sclk = 1'b1;
      step(1);
      o_din = tx[i]; // late change exposes rise sampling
      step(3);
      rx[i] = i_sdo;
      o_sclk = 1'b0;
      step(4);
    end
  endtask
endmodule

//--- tb/serial_register_port_checksum_bench.sv
// self-checking bench of the serial register port with a host model
// assumes a 10 MHz reference clock; the register file is modelled here
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("ERROR %0t got %0h expected %0h", $time, got, exp); \
  end \
end
module serial_register_port_checksum_bench;
  import srpc_pkg::*;

  logic               i_ref_clk  = 1'b0;
  logic               i_rst      = 1'b1;
  logic               i_wr_ready = 1'b1;
  logic               sclk, cs_n, din;
  logic               o_dout, o_dout_oe, o_wr_valid, o_gap_short;
  logic [ADDR_W-1:0]  o_rd_addr, o_wr_addr;
  logic [LANE_W-1:0]  o_wr_lane;
  logic [BYTE_W-1:0]  o_wr_data;
  logic [CKSUM_W-1:0] o_checksum;
  logic [DATA_W-1:0]  regv [32];
  logic [LANE_W-1:0]  regw [32];
  logic [WORD_W-1:0]  wq [$];
  int                 failures  = 0;
  int                 tests_run = 0;
  wire logic          sdo;
  wire logic [DATA_W-1:0] rd_data;
  wire logic [LANE_W-1:0] reg_bytes;

  // register file read side answers the addressed register
  assign rd_data   = regv[o_rd_addr];
  assign reg_bytes = regw[o_rd_addr];

  // data out wire floats when the port releases it
  assign sdo = o_dout_oe ? o_dout : 1'bz;

  // reference clock
  always #50 i_ref_clk = ~i_ref_clk;

  // register file write side collects every accepted byte
  always @(posedge i_ref_clk)
    if (o_wr_valid === 1'b1 && i_wr_ready)
      wq.push_back({o_wr_addr, o_wr_lane, o_wr_data});

  srpc_serial_port #(.FIFO_DEPTH(8)) uut (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_sclk      (sclk),
    .i_cs_n      (cs_n),
    .i_din       (din),
    .i_rd_data   (rd_data),
    .i_reg_bytes (reg_bytes),
    .i_wr_ready  (i_wr_ready),
    .o_dout      (o_dout),
    .o_dout_oe   (o_dout_oe),
    .o_rd_addr   (o_rd_addr),
    .o_wr_valid  (o_wr_valid),
    .o_wr_addr   (o_wr_addr),
    .o_wr_lane   (o_wr_lane),
    .o_wr_data   (o_wr_data),
    .o_checksum  (o_checksum),
    .o_gap_short (o_gap_short)
  );

  srpc_host host (
    .i_ref_clk (i_ref_clk),
    .i_sdo     (sdo),
    .o_sclk    (sclk),
    .o_cs_n    (cs_n),
    .o_din     (din)
  );

  // verdict and end of run
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // oldest collected write byte against the expected word
  task automatic exp_wr(input logic [ADDR_W-1:0] a,
                        input logic [LANE_W-1:0] l, input logic [7:0] d);
    logic [WORD_W-1:0] w;
    w = (wq.size() > 0) ? wq.pop_front() : '0;
    `CHK(w, {a, l, d})
  endtask

  // one read inside an open frame; n bytes of v, top byte first
  task automatic rd_reg(input logic [7:0] cmd, input int n,
                        input logic [DATA_W-1:0] v);
    logic [7:0] rx;
    host.shift(cmd, 8, rx);
    for (int k = n - 1; k >= 0; k--) begin
      host.shift(8'h00, 8, rx);
      if (k == n - 1)
        regv[cmd[ADDR_W-1:0]] = ~v;
      `CHK(rx, v[8*k +: 8])
    end
    `CHK(o_dout_oe, 1'b0)
    `CHK(o_checksum, CKSUM_W'($countones(v & ((24'h1 << 8*n) - 1))))
  endtask

  // quiet state after reset release
  task automatic t_reset();
    `CHK(o_dout_oe, 1'b0)
    `CHK(o_wr_valid, 1'b0)
    `CHK(o_checksum, 6'h00)
    `CHK(o_gap_short, 1'b0)
  endtask

  // three-byte write, then a one-byte write back to back, sink stalled
  task automatic t_write();
    logic [7:0] rx;
    i_wr_ready = 1'b0;
    host.start();
    host.shift(8'hE5, 8, rx);
    host.shift(8'hC1, 8, rx);
    host.shift(8'h5A, 8, rx);
    host.shift(8'h93, 8, rx);
    host.shift(8'h82, 8, rx);
    host.shift(8'h3C, 8, rx);
    host.stop();
    host.step(10);
    `CHK(o_wr_valid, 1'b1)
    `CHK(wq.size(), 0)
    i_wr_ready = 1'b1;
    host.step(10);
    exp_wr(5'h05, 2'h2, 8'hC1);
    exp_wr(5'h05, 2'h1, 8'h5A);
    exp_wr(5'h05, 2'h0, 8'h93);
    exp_wr(5'h02, 2'h0, 8'h3C);
  endtask

  // write cut short in its second byte, then a fresh frame
  task automatic t_abort_wr();
    logic [7:0] rx;
    host.start();
    host.shift(8'h89, 8, rx);
    host.shift(8'h0A, 8, rx);
    host.shift(8'hFF, 4, rx);
    host.stop();
    host.step(10);
    host.start();
    host.shift(8'h82, 8, rx);
    host.shift(8'h77, 8, rx);
    host.stop();
    host.step(10);
    exp_wr(5'h09, 2'h1, 8'h0A);
    exp_wr(5'h02, 2'h0, 8'h77);
    `CHK(wq.size(), 0)
  endtask

  // reads of three, two and one byte, the last being the ones count
  task automatic t_read();
    host.step(45);
    host.start();
    rd_reg(8'h01, 3, 24'hA50F81);
    rd_reg(8'h64, 2, 24'h000ABC);
    rd_reg(8'h1E, 1, 24'h000007);
    host.stop();
    `CHK(o_gap_short, 1'b0)
  endtask

  // read abandoned inside its first data byte
  task automatic t_abort_rd();
    logic [7:0] rx;
    host.step(4);
    host.start();
    host.shift(8'h06, 8, rx);
    host.shift(8'h00, 4, rx);
    `CHK(rx[7:4], 4'hF)
    host.stop();
    host.step(4);
    `CHK(o_dout_oe, 1'b0)
  endtask

  // reset pulled mid-write, then a frame with select held low throughout
  task automatic t_mid_reset();
    logic [7:0] rx;
    host.start();
    host.shift(8'h83, 8, rx);
    host.shift(8'hAA, 4, rx);
    i_rst = 1'b1;
    host.step(2);
    i_rst = 1'b0;
    host.step(4);
    `CHK(o_checksum, 6'h00)
    `CHK(o_wr_valid, 1'b0)
    host.shift(8'h82, 8, rx);
    host.shift(8'h5C, 8, rx);
    host.step(10);
    exp_wr(5'h02, 2'h0, 8'h5C);
    `CHK(wq.size(), 0)
    host.stop();
  endtask

  // watchdog reckoned well beyond the expected run length
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    failures++;
    wrap_up();
  end

  // register file contents, reset and the scenarios
  initial begin
    for (int a = 0; a < 32; a++) begin
      regv[a] = 24'h000000;
      regw[a] = 2'h1;
    end
    regw[5]  = 2'h3;
    regw[9]  = 2'h2;
    regw[1]  = 2'h3;
    regw[4]  = 2'h2;
    regw[6]  = 2'h3;
    regv[1]  = 24'hA50F81;
    regv[4]  = 24'h000ABC;
    regv[6]  = 24'hFFFFFF;
    regv[30] = 24'hFFFFFF;
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    host.step(4);
    t_reset();
    t_write();
    t_abort_wr();
    t_read();
    t_abort_rd();
    t_mid_reset();
    wrap_up();
  end
endmodule
